// *** core/dram_host_pkg.sv ***
// Constants, types and timing counts for the bank state tracking host
package dram_host_pkg;

  localparam int NUM_BANKS = 8;
  localparam int BANK_W = 3;
  localparam int CNT_W = 8;

  // Clock and timing figures
  localparam int CLK_PERIOD_NS = 40;
  localparam int PRECHARGE_PERIOD_NS = 18;
  localparam int ACT_TO_RW_DELAY_NS = 18;
  localparam int PER_BANK_REFRESH_PERIOD_NS = 90;
  localparam int ALL_BANK_REFRESH_PERIOD_NS = 130;
  localparam int ACTIVATE_TO_ACTIVATE_DELAY_NS = 10;
  localparam int POWER_DOWN_EXIT_DELAY_NS = 8;
  localparam int RESET_INIT_NS = 1000;
  localparam int MODE_READ_PERIOD_CK = 2;
  localparam int MODE_WRITE_PERIOD_CK = 5;
  localparam int BURST_CK = 4;

  // Least time in whole cycles, never below one
  function automatic int cyc_min(input int ns);
    int c;
    c = (ns + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    return (c < 1) ? 1 : c;
  endfunction

  localparam int PRE_CYC = cyc_min(PRECHARGE_PERIOD_NS);
  localparam int ACT_CYC = cyc_min(ACT_TO_RW_DELAY_NS);
  localparam int REFPB_CYC = cyc_min(PER_BANK_REFRESH_PERIOD_NS);
  localparam int REFAB_CYC = cyc_min(ALL_BANK_REFRESH_PERIOD_NS);
  localparam int RRD_CYC = cyc_min(ACTIVATE_TO_ACTIVATE_DELAY_NS);
  localparam int XP_CYC = cyc_min(POWER_DOWN_EXIT_DELAY_NS);
  localparam int RESET_CYC = cyc_min(RESET_INIT_NS);

  typedef enum logic [3:0] {
    C_NOP, C_ACT, C_READ, C_WRITE, C_PRE, C_REF_PB, C_REF_AB,
    C_MRW, C_MRR, C_RESET, C_BST
  } cmd_t;

  typedef enum logic [2:0] {
    B_IDLE, B_ACTIVATING, B_ACTIVE, B_READING, B_WRITING,
    B_PRECHARGING, B_AP_BURST, B_REFRESHING
  } bank_st_t;

  typedef enum logic [2:0] {
    D_POWER_ON, D_NORMAL, D_REF_ALL, D_MR_WRITE, D_MR_READ, D_RESETTING
  } dev_st_t;

endpackage

// *** core/dram_bank_state_tracker.sv ***
// Host command issuer that tracks bank and device state of the memory
`timescale 1ns/1ps
module dram_bank_state_tracker
  import dram_host_pkg::*;
(
  input wire logic sys_clk_i,
  input wire logic nrst_i,
  input wire logic req_valid_i,
  input wire cmd_t req_cmd_i,
  input wire logic [BANK_W-1:0] req_bank_i,
  input wire logic req_ap_i,
  output logic req_ack_o,
  output logic cke_o,
  output cmd_t cmd_o,
  output logic [BANK_W-1:0] bank_o,
  output logic ap_o,
  output logic all_idle_o,
  output logic burst_o
);

////////////////////////////////////////////////////////////////////////////
// Reset release
logic rst_meta_q;
logic rst_n_q;

always_ff @(posedge sys_clk_i or negedge nrst_i)
begin
  if (!nrst_i)
  begin
    rst_meta_q <= 1'b0;
    rst_n_q <= 1'b0;
  end
  else
  begin
    rst_meta_q <= 1'b1;
    rst_n_q <= rst_meta_q;
  end
end

////////////////////////////////////////////////////////////////////////////
// State and decode
bank_st_t st_q [NUM_BANKS];
bank_st_t st_d [NUM_BANKS];
logic [CNT_W-1:0] cnt_q [NUM_BANKS];
logic [CNT_W-1:0] cnt_d [NUM_BANKS];
dev_st_t dev_q;
dev_st_t dev_d;
logic [CNT_W-1:0] dcnt_q;
logic [CNT_W-1:0] dcnt_d;
logic [CNT_W-1:0] rrd_q;
logic [BANK_W-1:0] last_q;
logic cke_q;
logic legal;
logic [NUM_BANKS-1:0] is_idle;
logic [NUM_BANKS-1:0] is_act;
logic [NUM_BANKS-1:0] is_rw;
logic [NUM_BANKS-1:0] is_ap;
logic [NUM_BANKS-1:0] is_ref;

for (genvar g = 0; g < NUM_BANKS; g++)
begin : g_dec
  assign is_idle[g] = (st_q[g] == B_IDLE);
  assign is_act[g] = (st_q[g] == B_ACTIVE);
  assign is_rw[g] = (st_q[g] == B_READING) || (st_q[g] == B_WRITING);
  assign is_ap[g] = (st_q[g] == B_AP_BURST);
  assign is_ref[g] = (st_q[g] == B_REFRESHING);
end

wire bank_st_t sel_st = st_q[req_bank_i];
wire dev_free = (dev_q == D_NORMAL) && !(|is_ref);
wire any_burst = |(is_rw | is_ap);
wire all_idle = (dev_q == D_NORMAL) && (&is_idle);
wire pre_all_ok = &(is_idle | is_act);
wire burst_live = is_rw[last_q];
wire issue = req_valid_i && legal && cke_q;

////////////////////////////////////////////////////////////////////////////
// Legality of the pending request
always_comb
begin
  legal = 1'b0;
  unique case (req_cmd_i)
    C_NOP: legal = 1'b0;
    C_ACT: legal = dev_free && (sel_st == B_IDLE) && (rrd_q == '0);
    C_READ: legal = dev_free &&
      ((sel_st == B_ACTIVE) || (sel_st == B_READING));
    C_WRITE: legal = dev_free &&
      ((sel_st == B_ACTIVE) || (sel_st == B_WRITING));
    C_PRE: legal = dev_free && (req_ap_i ? pre_all_ok :
      ((sel_st == B_IDLE) || (sel_st == B_ACTIVE)));
    C_REF_PB: legal = dev_free && (sel_st == B_IDLE) && !any_burst;
    C_REF_AB: legal = all_idle;
    C_MRW: legal = all_idle;
    C_RESET: legal = all_idle ||
      ((dev_q == D_POWER_ON) && (dcnt_q == '0));
    C_MRR: legal = (dev_free && !any_burst &&
      (all_idle || (sel_st == B_ACTIVE))) || (dev_q == D_RESETTING);
    C_BST: legal = dev_free && burst_live;
    default: legal = 1'b0;
  endcase
end

////////////////////////////////////////////////////////////////////////////
// Bank next state
always_comb
begin
  for (int i = 0; i < NUM_BANKS; i++)
  begin
    st_d[i] = st_q[i];
    cnt_d[i] = (cnt_q[i] != '0) ? cnt_q[i] - 1'b1 : '0;
    if (cnt_q[i] == CNT_W'(1))
    begin
      unique case (st_q[i])
        B_ACTIVATING, B_READING, B_WRITING: st_d[i] = B_ACTIVE;
        B_PRECHARGING, B_AP_BURST, B_REFRESHING: st_d[i] = B_IDLE;
        default: st_d[i] = st_q[i];
      endcase
    end
    if (issue)
    begin
      unique case (req_cmd_i)
        C_ACT:
          if (BANK_W'(i) == req_bank_i)
          begin
            st_d[i] = B_ACTIVATING;
            cnt_d[i] = CNT_W'(ACT_CYC);
          end
        C_READ, C_WRITE:
          if (BANK_W'(i) == req_bank_i)
          begin
            if (req_ap_i)
            begin
              st_d[i] = B_AP_BURST;
              cnt_d[i] = CNT_W'(BURST_CK + PRE_CYC);
            end
            else
            begin
              st_d[i] = (req_cmd_i == C_READ) ? B_READING : B_WRITING;
              cnt_d[i] = CNT_W'(BURST_CK);
            end
          end
          else if (is_rw[i])
          begin
            st_d[i] = B_ACTIVE;
            cnt_d[i] = '0;
          end
        C_PRE:
          if (req_ap_i || (BANK_W'(i) == req_bank_i))
          begin
            st_d[i] = B_PRECHARGING;
            cnt_d[i] = CNT_W'(PRE_CYC);
          end
        C_REF_PB:
          if (BANK_W'(i) == req_bank_i)
          begin
            st_d[i] = B_REFRESHING;
            cnt_d[i] = CNT_W'(REFPB_CYC);
          end
        C_BST:
          if (BANK_W'(i) == last_q)
          begin
            st_d[i] = B_ACTIVE;
            cnt_d[i] = '0;
          end
        C_RESET:
        begin
          st_d[i] = B_IDLE;
          cnt_d[i] = '0;
        end
        default: st_d[i] = st_d[i];
      endcase
    end
  end
end

////////////////////////////////////////////////////////////////////////////
// Device next state
always_comb
begin
  dev_d = dev_q;
  dcnt_d = (cke_q && dcnt_q != '0) ? dcnt_q - 1'b1 : dcnt_q;
  if (dcnt_q == CNT_W'(1) && dev_q != D_POWER_ON)
    dev_d = D_NORMAL;
  if (issue)
  begin
    unique case (req_cmd_i)
      C_REF_AB:
      begin
        dev_d = D_REF_ALL;
        dcnt_d = CNT_W'(REFAB_CYC);
      end
      C_MRW:
      begin
        dev_d = D_MR_WRITE;
        dcnt_d = CNT_W'(MODE_WRITE_PERIOD_CK);
      end
      C_MRR:
      begin
        dev_d = D_MR_READ;
        dcnt_d = CNT_W'(MODE_READ_PERIOD_CK);
      end
      C_RESET:
      begin
        dev_d = D_RESETTING;
        dcnt_d = CNT_W'(RESET_CYC);
      end
      default: dev_d = dev_d;
    endcase
  end
end

////////////////////////////////////////////////////////////////////////////
// Registers
always_ff @(posedge sys_clk_i or negedge rst_n_q)
begin
  if (!rst_n_q)
  begin
    for (int i = 0; i < NUM_BANKS; i++)
    begin
      st_q[i] <= B_IDLE;
      cnt_q[i] <= '0;
    end
    dev_q <= D_POWER_ON;
    dcnt_q <= CNT_W'(XP_CYC);
  end
  else
  begin
    st_q <= st_d;
    cnt_q <= cnt_d;
    dev_q <= dev_d;
    dcnt_q <= dcnt_d;
  end
end

always_ff @(posedge sys_clk_i or negedge rst_n_q)
begin
  if (!rst_n_q)
  begin
    rrd_q <= '0;
    last_q <= '0;
    cke_q <= 1'b0;
    req_ack_o <= 1'b0;
    cmd_o <= C_NOP;
    bank_o <= '0;
    ap_o <= 1'b0;
    all_idle_o <= 1'b0;
    burst_o <= 1'b0;
  end
  else
  begin
    rrd_q <= (issue && req_cmd_i == C_ACT) ? CNT_W'(RRD_CYC) :
      ((rrd_q != '0) ? rrd_q - 1'b1 : '0);
    if (issue && (req_cmd_i == C_READ || req_cmd_i == C_WRITE))
      last_q <= req_bank_i;
    cke_q <= 1'b1;
    req_ack_o <= issue;
    cmd_o <= issue ? req_cmd_i : C_NOP;
    if (issue)
      bank_o <= req_bank_i;
    ap_o <= issue && req_ap_i;
    all_idle_o <= all_idle;
    burst_o <= any_burst;
  end
end

assign cke_o = cke_q;

////////////////////////////////////////////////////////////////////////////
// Assertions and cover points
property p_cke_first;
  @(posedge sys_clk_i) disable iff (!rst_n_q)
  (cmd_o != C_NOP) |-> cke_o && $past(cke_o);
endproperty
a_cke_first: assert property (p_cke_first) else $error("cmd without cke");

property p_refab_nop;
  @(posedge sys_clk_i) disable iff (!rst_n_q)
  (cmd_o == C_REF_AB) |=> (cmd_o == C_NOP) [*4];
endproperty
a_refab_nop: assert property (p_refab_nop) else $error("refab busy");

property p_refpb_nop;
  @(posedge sys_clk_i) disable iff (!rst_n_q)
  (cmd_o == C_REF_PB) |=> (cmd_o == C_NOP) [*3];
endproperty
a_refpb_nop: assert property (p_refpb_nop) else $error("refpb busy");

property p_mrw_nop;
  @(posedge sys_clk_i) disable iff (!rst_n_q)
  (cmd_o == C_MRW) |=> (cmd_o == C_NOP) [*5] ##1 all_idle_o;
endproperty
a_mrw_nop: assert property (p_mrw_nop) else $error("mrw busy");

property p_mrr_nop;
  @(posedge sys_clk_i) disable iff (!rst_n_q)
  (cmd_o == C_MRR) |=> (cmd_o == C_NOP) [*2];
endproperty
a_mrr_nop: assert property (p_mrr_nop) else $error("mrr busy");

property p_act_space;
  @(posedge sys_clk_i) disable iff (!rst_n_q)
  (cmd_o == C_ACT) |=> (cmd_o != C_ACT);
endproperty
a_act_space: assert property (p_act_space) else $error("act spacing");

property p_act_to_rw;
  @(posedge sys_clk_i) disable iff (!rst_n_q)
  (cmd_o == C_ACT) ##1 (cmd_o == C_READ || cmd_o == C_WRITE) |->
    bank_o != $past(bank_o);
endproperty
a_act_to_rw: assert property (p_act_to_rw) else $error("act delay");

property p_bst_live;
  @(posedge sys_clk_i) disable iff (!rst_n_q)
  (issue && req_cmd_i == C_BST) |-> burst_live ##1 (cmd_o == C_BST);
endproperty
a_bst_live: assert property (p_bst_live) else $error("bst no burst");

property p_wr_after_rd;
  @(posedge sys_clk_i) disable iff (!rst_n_q)
  (issue && req_cmd_i == C_WRITE) |-> sel_st != B_READING;
endproperty
a_wr_after_rd: assert property (p_wr_after_rd) else $error("wr in rd");

property p_all_idle_cmds;
  @(posedge sys_clk_i) disable iff (!rst_n_q)
  (issue && (req_cmd_i == C_REF_AB || req_cmd_i == C_MRW)) |->
    (&is_idle) && !any_burst;
endproperty
a_all_idle_cmds: assert property (p_all_idle_cmds) else $error("not idle");

property p_ap_busy;
  @(posedge sys_clk_i) disable iff (!rst_n_q)
  ((cmd_o == C_READ || cmd_o == C_WRITE) && ap_o) |=>
    (cmd_o == C_NOP || bank_o != $past(bank_o, 1)) ##1
    (cmd_o == C_NOP || bank_o != $past(bank_o, 2)) ##1
    (cmd_o == C_NOP || bank_o != $past(bank_o, 3)) ##1
    (cmd_o == C_NOP || bank_o != $past(bank_o, 4)) ##1
    (cmd_o == C_NOP || bank_o != $past(bank_o, 5));
endproperty
a_ap_busy: assert property (p_ap_busy) else $error("ap interrupted");

c_refab: cover property (@(posedge sys_clk_i) disable iff (!rst_n_q)
  cmd_o == C_REF_AB);
c_rd_bst: cover property (@(posedge sys_clk_i) disable iff (!rst_n_q)
  cmd_o == C_READ ##[1:3] cmd_o == C_BST);
c_ap_wr: cover property (@(posedge sys_clk_i) disable iff (!rst_n_q)
  cmd_o == C_WRITE && ap_o);
c_reset_mrr: cover property (@(posedge sys_clk_i) disable iff (!rst_n_q)
  cmd_o == C_RESET ##[1:20] cmd_o == C_MRR);

endmodule // dram_bank_state_tracker

// *** dv/dram_device_model.sv ***
// Behavioural memory device that checks every registered command
`timescale 1ns/1ps
module dram_device_model
  import dram_host_pkg::*;
(
  input wire logic sys_clk_i,
  input wire logic nrst_i,
  input wire logic cke_i,
  input wire cmd_t cmd_i,
  input wire logic [BANK_W-1:0] bank_i,
  input wire logic ap_i,
  output int n_viol_o
);
  bank_st_t st [NUM_BANKS];
  int t [NUM_BANKS];
  dev_st_t dev;
  int dt, rt, rrd;
  logic cke_q, ok, idle, pre_ok, busy;
  logic [BANK_W-1:0] last_q;
  bank_st_t sb;
  ////////////////////////////////////////////////////////////////////////////
  assign sb = st[bank_i];
  always_comb
  begin
    idle = (dev == D_NORMAL);
    pre_ok = 1'b1;
    busy = 1'b0;
    for (int i = 0; i < NUM_BANKS; i++)
    begin
      idle &= (st[i] == B_IDLE);
      pre_ok &= (st[i] inside {B_IDLE, B_ACTIVE});
      busy |= (st[i] inside {B_READING, B_WRITING, B_AP_BURST});
    end
    case (cmd_i)
      C_ACT: ok = (sb == B_IDLE) && (rrd == 0);
      C_READ: ok = sb inside {B_ACTIVE, B_READING};
      C_WRITE: ok = sb inside {B_ACTIVE, B_WRITING};
      C_PRE: ok = ap_i ? pre_ok : sb inside {B_IDLE, B_ACTIVE};
      C_REF_PB: ok = (sb == B_IDLE) && !busy;
      C_REF_AB, C_MRW: ok = idle;
      C_MRR: ok = idle || sb == B_ACTIVE || dev == D_RESETTING;
      C_RESET: ok = idle || dev == D_POWER_ON;
      C_BST: ok = st[last_q] inside {B_READING, B_WRITING};
      default: ok = 1'b0;
    endcase
    ok &= (dt == 0) && cke_i && cke_q;
    ok &= (dev == D_NORMAL) || (dev == D_POWER_ON && cmd_i == C_RESET)
      || (dev == D_RESETTING && cmd_i == C_MRR);
  end
  ////////////////////////////////////////////////////////////////////////////
  always_ff @(posedge sys_clk_i or negedge nrst_i)
    if (!nrst_i)
    begin
      for (int i = 0; i < NUM_BANKS; i++)
      begin
        st[i] <= B_IDLE;
        t[i] <= 0;
      end
      dev <= D_POWER_ON;
      dt <= 0;
      rt <= 0;
      rrd <= 0;
      cke_q <= 1'b0;
      last_q <= 3'h0;
      n_viol_o <= 0;
    end
    else
    begin
      cke_q <= cke_i;
      if (cmd_i != C_NOP && !ok)
        n_viol_o <= n_viol_o + 1;
      if (dt > 0)
        dt <= dt - 1;
      if (rrd > 0)
        rrd <= rrd - 1;
      if (rt > 0)
        rt <= rt - 1;
      if (rt == 1)
        dev <= D_NORMAL;
      for (int i = 0; i < NUM_BANKS; i++)
        if (t[i] > 0)
        begin
          t[i] <= t[i] - 1;
          if (t[i] == 1)
            st[i] <= (st[i] inside {B_ACTIVATING, B_READING, B_WRITING}) ?
              B_ACTIVE : B_IDLE;
        end
      if (ok)
        case (cmd_i)
          C_ACT:
          begin
            st[bank_i] <= B_ACTIVATING;
            t[bank_i] <= ACT_CYC;
            rrd <= RRD_CYC;
          end
          C_READ, C_WRITE:
          begin
            for (int i = 0; i < NUM_BANKS; i++)
              if (st[i] inside {B_READING, B_WRITING})
              begin
                st[i] <= B_ACTIVE;
                t[i] <= 0;
              end
            st[bank_i] <= ap_i ? B_AP_BURST :
              (cmd_i == C_READ) ? B_READING : B_WRITING;
            t[bank_i] <= ap_i ? BURST_CK + PRE_CYC - 1 : BURST_CK - 1;
            last_q <= bank_i;
          end
          C_PRE:
          begin
            for (int i = 0; i < NUM_BANKS; i++)
              if (ap_i || i == int'(bank_i))
              begin
                st[i] <= B_PRECHARGING;
                t[i] <= PRE_CYC;
              end
            if (ap_i)
              dt <= PRE_CYC;
          end
          C_REF_PB:
          begin
            st[bank_i] <= B_REFRESHING;
            t[bank_i] <= REFPB_CYC;
            dt <= REFPB_CYC;
          end
          C_REF_AB: dt <= REFAB_CYC;
          C_MRW: dt <= MODE_WRITE_PERIOD_CK;
          C_MRR:
          begin
            dt <= MODE_READ_PERIOD_CK;
            dev <= D_NORMAL;
            rt <= 0;
          end
          C_RESET:
          begin
            dev <= D_RESETTING;
            rt <= RESET_CYC;
          end
          C_BST:
          begin
            st[last_q] <= B_ACTIVE;
            t[last_q] <= 0;
          end
          default: ;
        endcase
    end
endmodule // dram_device_model

// *** dv/dram_bank_state_tracker_bench.sv ***
// Self-checking bench of the bank state tracker against the device model
`timescale 1ns/1ps
module dram_bank_state_tracker_bench
  import dram_host_pkg::*;
;
  typedef struct {cmd_t c; logic [BANK_W-1:0] b; logic a; int g;} note_t;
  localparam int LIMIT = 3000;
  logic sys_clk_i = 1'b0;
  logic nrst_i = 1'b0;
  logic req_valid_i = 1'b0;
  cmd_t req_cmd_i = C_NOP;
  logic [BANK_W-1:0] req_bank_i = 3'h0;
  logic req_ap_i = 1'b0;
  logic req_ack_o, cke_o, ap_o, all_idle_o, burst_o;
  cmd_t cmd_o;
  logic [BANK_W-1:0] bank_o, r;
  int num_errors = 0;
  int n_tests = 0;
  int cyc = 0;
  int last = 0;
  int n_viol;
  note_t exp_q [$];
  note_t e;
  logic [15:0] rnd = 16'hC531;
  ////////////////////////////////////////////////////////////////////////////
  dram_bank_state_tracker i_dram_bank_state_tracker (.sys_clk_i(sys_clk_i),
    .nrst_i(nrst_i), .req_valid_i(req_valid_i), .req_cmd_i(req_cmd_i),
    .req_bank_i(req_bank_i), .req_ap_i(req_ap_i), .req_ack_o(req_ack_o),
    .cke_o(cke_o), .cmd_o(cmd_o), .bank_o(bank_o), .ap_o(ap_o),
    .all_idle_o(all_idle_o), .burst_o(burst_o));
  dram_device_model i_dram_device_model (.sys_clk_i(sys_clk_i),
    .nrst_i(nrst_i), .cke_i(cke_o), .cmd_i(cmd_o), .bank_i(bank_o),
    .ap_i(ap_o), .n_viol_o(n_viol));
  initial
    forever #20 sys_clk_i = ~sys_clk_i;
  ////////////////////////////////////////////////////////////////////////////
  function automatic logic [15:0] lfsr(input logic [15:0] v);
    return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
  endfunction
  task automatic check(input logic [31:0] seen, input logic [31:0] want);
    n_tests++;
    if (seen !== want)
    begin
      num_errors++;
      $display("BAD t=%0t seen=%h want=%h", $time, seen, want);
    end
  endtask
  task automatic report_and_stop();
    $display("comparisons=%0d errors=%0d", n_tests, num_errors);
    if (num_errors == 0 && n_tests > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  task automatic issue(input cmd_t c, input int b, input logic a, input int g);
    int k;
    k = 0;
    req_valid_i = 1'b1;
    req_cmd_i = c;
    req_bank_i = b[BANK_W-1:0];
    req_ap_i = a;
    exp_q.push_back('{c, b[BANK_W-1:0], a, g});
    do
    begin
      @(negedge sys_clk_i);
      k++;
    end
    while (req_ack_o !== 1'b1 && k < 100);
  endtask
  task automatic refuse(input cmd_t c, input int b);
    req_valid_i = 1'b1;
    req_cmd_i = c;
    req_bank_i = b[BANK_W-1:0];
    req_ap_i = 1'b0;
    repeat (12) @(negedge sys_clk_i);
    req_valid_i = 1'b0;
    @(negedge sys_clk_i);
  endtask
  ////////////////////////////////////////////////////////////////////////////
  always @(negedge sys_clk_i)
  begin
    cyc++;
    if (cyc > LIMIT)
    begin
      num_errors++;
      report_and_stop();
    end
    else if (req_ack_o === 1'b1)
    begin
      if (exp_q.size() == 0)
        check(32'h1, 32'h0);
      else
      begin
        e = exp_q.pop_front();
        check(cmd_o, e.c);
        check(bank_o, e.b);
        check(ap_o, e.a);
        if (e.g > 0)
          check(cyc - last, e.g);
      end
      last = cyc;
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  initial
  begin
    repeat (10) @(negedge sys_clk_i);
    check(cke_o, 1'b0);
    check(cmd_o, C_NOP);
    nrst_i = 1'b1;
    rnd = lfsr(rnd);
    r = rnd[2:0];
    issue(C_RESET, 0, 1'b0, 0);
    issue(C_MRR, 0, 1'b0, 1);
    issue(C_MRW, 0, 1'b0, MODE_READ_PERIOD_CK + 1);
    issue(C_REF_AB, 0, 1'b0, MODE_WRITE_PERIOD_CK + 1);
    issue(C_ACT, r, 1'b0, REFAB_CYC + 1);
    issue(C_ACT, r + 3'h1, 1'b0, RRD_CYC + 1);
    issue(C_READ, r, 1'b0, 1);
    req_valid_i = 1'b0;
    @(negedge sys_clk_i);
    check(burst_o, 1'b1);
    issue(C_WRITE, r, 1'b0, BURST_CK + 1);
    issue(C_READ, r, 1'b0, BURST_CK + 1);
    issue(C_BST, r, 1'b0, 1);
    issue(C_WRITE, r, 1'b1, 1);
    issue(C_ACT, r, 1'b0, BURST_CK + PRE_CYC + 1);
    issue(C_PRE, r, 1'b0, ACT_CYC + 1);
    issue(C_PRE, 0, 1'b1, PRE_CYC + 1);
    issue(C_REF_PB, r, 1'b0, PRE_CYC + 1);
    issue(C_MRR, r, 1'b0, REFPB_CYC + 1);
    refuse(C_WRITE, r);
    refuse(C_BST, r);
    refuse(C_NOP, r);
    check(all_idle_o, 1'b1);
    check(burst_o, 1'b0);
    issue(C_PRE, r, 1'b0, 0);
    issue(C_ACT, r, 1'b0, PRE_CYC + 1);
    issue(C_PRE, 0, 1'b1, 0);
    repeat (8)
    begin
      rnd = lfsr(rnd);
      r = rnd[2:0];
      issue(C_ACT, r, 1'b0, 0);
      issue(rnd[4] ? C_READ : C_WRITE, r, rnd[3], ACT_CYC + 1);
      if (!rnd[3])
      begin
        issue(C_BST, r, 1'b0, 1);
        issue(C_PRE, r, 1'b0, 1);
      end
    end
    issue(C_PRE, 0, 1'b1, 0);
    issue(C_RESET, 0, 1'b0, PRE_CYC + 1);
    issue(C_MRW, 0, 1'b0, RESET_CYC + 1);
    req_valid_i = 1'b0;
    repeat (8) @(negedge sys_clk_i);
    check(cke_o, 1'b1);
    check(n_viol, 0);
    check(exp_q.size(), 0);
    report_and_stop();
  end
endmodule // dram_bank_state_tracker_bench
